// ### design/csf_top.sv
// capacitive sense mode decode, timer clock routing and counting timers
//
// Function
// - reference-mode bit picks fixed or variable references
// - decode range field per reference mode
// - noise mode disables only the current source
// - sense oscillator clocks first or second timer
// - first timer uses oscillator when select set, external
// - second timer uses oscillator on source code 11
// - second timer on bit and gate enable
// - status bit shows source or sink direction
// - first timer stops during sleep
`timescale 1ns/100ps
`default_nettype none
`include "csf_regs.svh"

module csf_top
  import csf_pkg::*;
(
  input  wire logic                 clock,                 // 50 MHz system clock
  input  wire logic                 rst_b,                 // async reset, active low
  input  wire logic                 clk_en,                // freezes all state while low
  input  wire logic                 ctrl0_wr,              // load sense control word
  input  wire csf_ctrl0_t           ctrl0_in,              // sense control word
  input  wire logic                 ta_src_wr,             // load first timer source bit
  input  wire logic                 timer_a_clk_src,       // 1 internal, 0 external
  input  wire logic                 tb_ctrl_wr,            // load second timer control
  input  wire csf_tb_ctrl_t         tb_ctrl_in,            // second timer control
  input  wire logic                 sleep_active,          // core is asleep
  input  wire logic                 timer_a_clear,         // clear first timer
  input  wire logic                 timer_b_clear,         // clear second timer
  input  wire logic                 ta_ovf_clear,          // clear first timer overflow flag
  input  wire logic                 sense_osc_in,          // comparator output of the oscillator
  input  wire logic                 timer_a_pin,           // external clock pin of first timer
  input  wire logic                 timer_b_pin,           // external clock pin of second timer
  input  wire logic                 timer_b_gate_in,       // gate level of second timer
  output var  csf_analog_t          analog_ctrl,           // controls to the oscillator
  output var  logic                 osc_direction_status,  // 1 sourcing, 0 sinking
  output var  logic                 sense_on_timer_a,      // oscillator clocks first timer
  output var  logic                 sense_on_timer_b,      // oscillator clocks second timer
  output var  logic [`CSF_TA_W-1:0] timer_a_count,         // first timer value
  output var  logic [`CSF_TB_W-1:0] timer_b_count,         // second timer value
  output var  logic                 timer_a_ovf            // sticky first timer overflow
);

  // decode of reference mode and range into oscillator controls
  function automatic csf_analog_t decode_analog(input csf_ctrl0_t c);
    csf_analog_t a;
    a.var_ref_sel    = c.ref_mode_sel;
    a.osc_path_en    = c.enable;
    a.current_src_en = c.enable;
    a.range          = CSF_RNG_OFF;
    unique case (c.current_range_sel)
      `CSF_RNG_CODE_OFF: begin
        if (c.ref_mode_sel) begin
          a.range          = CSF_RNG_NOISE;
          a.current_src_en = 1'b0;
        end else begin
          a.range          = CSF_RNG_OFF;
          a.current_src_en = 1'b0;
          a.osc_path_en    = 1'b0;
        end
      end
      `CSF_RNG_CODE_LOW:  a.range = CSF_RNG_LOW;
      `CSF_RNG_CODE_MED:  a.range = CSF_RNG_MED;
      `CSF_RNG_CODE_HIGH: a.range = CSF_RNG_HIGH;
    endcase
    if (!c.enable) begin
      a.range = CSF_RNG_OFF;
    end
    return a;
  endfunction

  // configuration state
  csf_ctrl0_t   ctrl0_q;      // sense control word
  csf_ctrl0_t   ctrl0_d;
  logic         ta_src_q;     // first timer source bit
  logic         ta_src_d;
  csf_tb_ctrl_t tb_ctrl_q;    // second timer control
  csf_tb_ctrl_t tb_ctrl_d;

  // output and counting state
  csf_analog_t          analog_q;   // registered oscillator controls
  csf_analog_t          analog_d;
  logic                 dir_q;      // registered direction status
  logic                 dir_d;
  logic                 on_a_q;     // oscillator routed to first timer
  logic                 on_a_d;
  logic                 on_b_q;     // oscillator routed to second timer
  logic                 on_b_d;
  logic [`CSF_TA_W-1:0] ta_q;       // first timer counter
  logic [`CSF_TA_W-1:0] ta_d;
  logic [`CSF_TB_W-1:0] tb_q;       // second timer counter
  logic [`CSF_TB_W-1:0] tb_d;
  logic                 ovf_q;      // sticky overflow of first timer
  logic                 ovf_d;

  // synchronised inputs
  logic osc_level;   // oscillator level after filtering
  logic osc_rise;    // oscillator rising edge
  logic pa_rise;     // first timer pin rising edge
  logic pb_rise;     // second timer pin rising edge
  logic gate_level;  // second timer gate level

  // count enables
  logic ta_tick;     // first timer increments this cycle
  logic tb_run;      // second timer allowed to run
  logic tb_tick;     // second timer increments this cycle

  // oscillator edges into the clock domain
  csf_edge_sync u_sync_osc (
    .clock    (clock),
    .rst_b    (rst_b),
    .clk_en   (clk_en),
    .async_in (sense_osc_in),
    .level    (osc_level),
    .rise     (osc_rise)
  );

  // first timer external pin
  csf_edge_sync u_sync_pa (
    .clock    (clock),
    .rst_b    (rst_b),
    .clk_en   (clk_en),
    .async_in (timer_a_pin),
    .level    (),
    .rise     (pa_rise)
  );

  // second timer external pin
  csf_edge_sync u_sync_pb (
    .clock    (clock),
    .rst_b    (rst_b),
    .clk_en   (clk_en),
    .async_in (timer_b_pin),
    .level    (),
    .rise     (pb_rise)
  );

  // second timer gate level
  csf_edge_sync u_sync_gate (
    .clock    (clock),
    .rst_b    (rst_b),
    .clk_en   (clk_en),
    .async_in (timer_b_gate_in),
    .level    (gate_level),
    .rise     ()
  );

  // configuration next values from software writes
  always_comb begin
    ctrl0_d   = ctrl0_wr   ? ctrl0_in        : ctrl0_q;
    ta_src_d  = ta_src_wr  ? timer_a_clk_src : ta_src_q;
    tb_ctrl_d = tb_ctrl_wr ? tb_ctrl_in      : tb_ctrl_q;
  end

  // configuration registers
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ctrl0_q   <= `CSF_C0_RESET;
      ta_src_q  <= `CSF_TA_SRC_RESET;
      tb_ctrl_q <= `CSF_TB_RESET;
    end else if (clk_en) begin
      ctrl0_q   <= ctrl0_d;
      ta_src_q  <= ta_src_d;
      tb_ctrl_q <= tb_ctrl_d;
    end
  end

  // routing, count enables and counter next values
  always_comb begin
    analog_d = decode_analog(ctrl0_q);
    dir_d    = ctrl0_q.enable & osc_level;
    // oscillator to first timer only with select set and external source
    on_a_d   = ctrl0_q.sense_to_timer_a_sel & (ta_src_q == `CSF_TA_SRC_EXT);
    // oscillator to second timer on source code 11
    on_b_d   = (tb_ctrl_q.timer_b_clk_src == `CSF_TB_SRC_SENSE);
    // first timer source select, halted in sleep
    if (sleep_active) begin
      ta_tick = 1'b0;
    end else if (ta_src_q != `CSF_TA_SRC_EXT) begin
      ta_tick = 1'b1;
    end else if (on_a_q) begin
      ta_tick = osc_rise & ctrl0_q.enable;
    end else begin
      ta_tick = pa_rise;
    end
    // second timer on bit and gate
    tb_run = tb_ctrl_q.timer_b_on & (~tb_ctrl_q.timer_b_gate_en | gate_level);
    if (!tb_run) begin
      tb_tick = 1'b0;
    end else if (on_b_q) begin
      tb_tick = osc_rise & ctrl0_q.enable;
    end else if (tb_ctrl_q.timer_b_clk_src == `CSF_TB_SRC_PIN) begin
      tb_tick = pb_rise;
    end else begin
      tb_tick = 1'b1;
    end
    // counters: clear wins over a tick so a window starts at zero
    ta_d = ta_q;
    if (timer_a_clear) begin
      ta_d = '0;
    end else if (ta_tick) begin
      ta_d = ta_q + `CSF_TA_W'(1);
    end
    tb_d = tb_q;
    if (timer_b_clear) begin
      tb_d = '0;
    end else if (tb_tick) begin
      tb_d = tb_q + `CSF_TB_W'(1);
    end
    // overflow flag: a wrap in a flag clear cycle still sets it, a tick under counter clear does not
    ovf_d = ovf_q;
    if (ta_tick && !timer_a_clear && (ta_q == {`CSF_TA_W{1'b1}})) begin
      ovf_d = 1'b1;
    end else if (ta_ovf_clear) begin
      ovf_d = 1'b0;
    end
  end

  // routing and counter registers
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      analog_q <= '0;
      dir_q    <= 1'b0;
      on_a_q   <= 1'b0;
      on_b_q   <= 1'b0;
      ta_q     <= '0;
      tb_q     <= '0;
      ovf_q    <= 1'b0;
    end else if (clk_en) begin
      analog_q <= analog_d;
      dir_q    <= dir_d;
      on_a_q   <= on_a_d;
      on_b_q   <= on_b_d;
      ta_q     <= ta_d;
      tb_q     <= tb_d;
      ovf_q    <= ovf_d;
    end
  end

  // outputs straight from flops
  assign analog_ctrl          = analog_q;
  assign osc_direction_status = dir_q;
  assign sense_on_timer_a     = on_a_q;
  assign sense_on_timer_b     = on_b_q;
  assign timer_a_count        = ta_q;
  assign timer_b_count        = tb_q;
  assign timer_a_ovf          = ovf_q;

endmodule

`default_nettype wire

// ### inc/csf_regs.svh
// constants for the capacitive sense frequency measurement block
`ifndef CSF_REGS_SVH
`define CSF_REGS_SVH

// range field encodings
`define CSF_RNG_CODE_OFF     2'b00
`define CSF_RNG_CODE_LOW     2'b01
`define CSF_RNG_CODE_MED     2'b10
`define CSF_RNG_CODE_HIGH    2'b11

// second timer clock-source code that picks the sense oscillator
`define CSF_TB_SRC_SENSE     2'b11
// second timer clock-source code that picks the external pin
`define CSF_TB_SRC_PIN       2'b10

// first timer clock-source bit value that selects an external source
`define CSF_TA_SRC_EXT       1'b0

// field positions of the sense control word
`define CSF_C0_TA_SEL_POS    0
`define CSF_C0_RANGE_POS     2
`define CSF_C0_REF_POS       6
`define CSF_C0_EN_POS        7

// reset values
`define CSF_C0_RESET         5'h00
`define CSF_TB_RESET         4'h0
`define CSF_TA_SRC_RESET     1'b1

// counter widths
`define CSF_TA_W             8
`define CSF_TB_W             16

`endif

// ### inc/csf_pkg.sv
// types shared by the capacitive sense frequency measurement block
package csf_pkg;

  // decoded oscillator current range
  typedef enum logic [2:0] {
    CSF_RNG_OFF,
    CSF_RNG_NOISE,
    CSF_RNG_LOW,
    CSF_RNG_MED,
    CSF_RNG_HIGH
  } csf_range_t;

  // sense control word as written by software
  typedef struct packed {
    logic       enable;
    logic       ref_mode_sel;
    logic [1:0] current_range_sel;
    logic       sense_to_timer_a_sel;
  } csf_ctrl0_t;

  // second timer control as written by software
  typedef struct packed {
    logic [1:0] timer_b_clk_src;
    logic       timer_b_on;
    logic       timer_b_gate_en;
  } csf_tb_ctrl_t;

  // controls toward the analog oscillator
  typedef struct packed {
    logic       osc_path_en;
    logic       current_src_en;
    logic       var_ref_sel;
    csf_range_t range;
  } csf_analog_t;

endpackage

// ### design/csf_edge_sync.sv
// three-stage synchroniser with agreement filter and rising-edge pulse
`timescale 1ns/100ps
`default_nettype none

module csf_edge_sync
  import csf_pkg::*;
(
  input  wire logic clock,     // system clock
  input  wire logic rst_b,     // async reset, active low
  input  wire logic clk_en,    // freezes state while low
  input  wire logic async_in,  // level from outside the clock domain
  output var  logic level,     // filtered level
  output var  logic rise       // one-cycle pulse on filtered rise
);

  logic [2:0] sync_q;  // stage 0 read only by stage 1
  logic [2:0] sync_d;
  logic       level_q; // accepted level
  logic       level_d;
  logic       rise_q;  // rise pulse
  logic       rise_d;

  // next values: accept a change once stages 1 and 2 agree
  always_comb begin
    sync_d  = {sync_q[1:0], async_in};
    level_d = level_q;
    rise_d  = 1'b0;
    if (sync_q[1] == sync_q[2]) begin
      level_d = sync_q[2];
      rise_d  = sync_q[2] & ~level_q;
    end
  end

  // registers, frozen while the enable is low
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sync_q  <= 3'h0;
      level_q <= 1'b0;
      rise_q  <= 1'b0;
    end else if (clk_en) begin
      sync_q  <= sync_d;
      level_q <= level_d;
      rise_q  <= rise_d;
    end
  end

  assign level = level_q;
  assign rise  = rise_q;

endmodule

`default_nettype wire

// ### bench/csf_top_sva.sv
// port assertions for the sense block
`timescale 1ns/100ps
`default_nettype none
`include "csf_regs.svh"
module csf_top_sva
  import csf_pkg::*;
(
  input wire logic                 clock,
  input wire logic                 rst_b,
  input wire logic                 clk_en,
  input wire logic                 ctrl0_wr,
  input wire csf_ctrl0_t           ctrl0_in,
  input wire logic                 ta_src_wr,
  input wire logic                 timer_a_clk_src,
  input wire logic                 tb_ctrl_wr,
  input wire csf_tb_ctrl_t         tb_ctrl_in,
  input wire logic                 sleep_active,
  input wire logic                 timer_a_clear,
  input wire logic                 timer_b_clear,
  input wire csf_analog_t          analog_ctrl,
  input wire logic                 sense_on_timer_a,
  input wire logic                 sense_on_timer_b,
  input wire logic [`CSF_TA_W-1:0] timer_a_count,
  input wire logic [`CSF_TB_W-1:0] timer_b_count
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  // expected range of a written word
  function automatic csf_range_t rng_of(logic rm, logic [1:0] r);
    if (r == 2'h0) return rm ? CSF_RNG_NOISE : CSF_RNG_OFF;
    return (r == 2'h1) ? CSF_RNG_LOW : (r == 2'h2) ? CSF_RNG_MED : CSF_RNG_HIGH;
  endfunction
  // enabled control write then a quiet cycle
  sequence c0_s;
    ctrl0_wr && clk_en && ctrl0_in.enable ##1 clk_en && !ctrl0_wr;
  endsequence
  AST_REF_MODE: assert property (c0_s |=> analog_ctrl.var_ref_sel == $past(ctrl0_in.ref_mode_sel, 2))
    else $error("reference select wrong");
  AST_RANGE: assert property (c0_s |=>
    analog_ctrl.range == rng_of($past(ctrl0_in.ref_mode_sel, 2), $past(ctrl0_in.current_range_sel, 2)))
    else $error("range decode wrong");
  AST_NOISE: assert property (analog_ctrl.range == CSF_RNG_NOISE |->
    analog_ctrl.osc_path_en && !analog_ctrl.current_src_en) else $error("noise mode controls wrong");
  AST_TA_ROUTE: assert property (((ctrl0_wr && !ctrl0_in.sense_to_timer_a_sel) ||
    (ta_src_wr && timer_a_clk_src)) && clk_en ##1 clk_en && !ctrl0_wr && !ta_src_wr |=> !sense_on_timer_a)
    else $error("first timer routed wrongly");
  AST_TB_ROUTE: assert property (tb_ctrl_wr && clk_en ##1 clk_en && !tb_ctrl_wr |=>
    sense_on_timer_b == ($past(tb_ctrl_in.timer_b_clk_src, 2) == `CSF_TB_SRC_SENSE))
    else $error("second timer routed wrongly");
  AST_STEP: assert property ($changed(timer_b_count) && !$past(timer_b_clear) |->
    timer_b_count == $past(timer_b_count) + 16'h1) else $error("second timer step not one");
  AST_CLEAR: assert property (timer_b_clear && clk_en |=> timer_b_count == 16'h0)
    else $error("second timer not cleared");
  AST_SLEEP: assert property (sleep_active && clk_en && !timer_a_clear |=> $stable(timer_a_count))
    else $error("first timer ran in sleep");
  AST_RESET: assert property ($rose(rst_b) |-> analog_ctrl.range == CSF_RNG_OFF && !analog_ctrl.var_ref_sel)
    else $error("reset state wrong");
endmodule
bind csf_top csf_top_sva u_sva (.clock, .rst_b, .clk_en, .ctrl0_wr, .ctrl0_in, .ta_src_wr, .timer_a_clk_src,
  .tb_ctrl_wr, .tb_ctrl_in, .sleep_active, .timer_a_clear, .timer_b_clear, .analog_ctrl, .sense_on_timer_a,
  .sense_on_timer_b, .timer_a_count, .timer_b_count);
`default_nettype wire

// ### bench/csf_pad_model.sv
// behavioural sense pad with relaxation oscillator
`timescale 1ns/100ps
`default_nettype none
module csf_pad_model
  import csf_pkg::*;
(
  input  wire csf_analog_t ctl,     // controls from the block
  input  wire logic        loaded,  // finger on the pad
  input  wire logic        noise,   // outside noise on the pin
  output var  logic        osc      // comparator output
);
  // toggles only while current or noise drives the pad, else holds
  initial osc = 1'b0;
  always begin
    if (ctl.osc_path_en && (ctl.current_src_en || noise)) #(loaded ? 140 : 100) osc = !osc;
    else #20;
  end
endmodule
`default_nettype wire

// ### bench/csf_top_tb.sv
// self-checking bench for the sense block
`timescale 1ns/100ps
`default_nettype none
`include "csf_regs.svh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_fail++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module csf_top_tb
  import csf_pkg::*;
;
  logic clock = 1'b0, rst_b = 1'b0, clk_en = 1'b1;
  logic w0 = 1'b0, wa = 1'b0, ta_src = 1'b1, wb = 1'b0, slp = 1'b0, ta_clr = 1'b0, tb_clr = 1'b0;
  logic ovf_clr = 1'b0, gate = 1'b0, loaded = 1'b0, noise = 1'b0, osc, dir, on_a, on_b, ovf;
  logic pin_a = 1'b0, pin_b = 1'b0;
  csf_ctrl0_t c0 = '0;
  csf_tb_ctrl_t cb = '0;
  csf_analog_t ac;
  logic [7:0] cnt_a, va;
  logic [15:0] cnt_b, v, nom, ld, thr;
  int n_fail = 0, checks_done = 0;
  csf_range_t exp_rng[8] = '{CSF_RNG_OFF, CSF_RNG_LOW, CSF_RNG_MED, CSF_RNG_HIGH,
                             CSF_RNG_NOISE, CSF_RNG_LOW, CSF_RNG_MED, CSF_RNG_HIGH};
  always #10 clock = ~clock;
  csf_top uut (.clock, .rst_b, .clk_en, .ctrl0_wr(w0), .ctrl0_in(c0), .ta_src_wr(wa), .timer_a_clk_src(ta_src),
    .tb_ctrl_wr(wb), .tb_ctrl_in(cb), .sleep_active(slp), .timer_a_clear(ta_clr), .timer_b_clear(tb_clr),
    .ta_ovf_clear(ovf_clr), .sense_osc_in(osc), .timer_a_pin(pin_a), .timer_b_pin(pin_b), .timer_b_gate_in(gate),
    .analog_ctrl(ac), .osc_direction_status(dir), .sense_on_timer_a(on_a), .sense_on_timer_b(on_b),
    .timer_a_count(cnt_a), .timer_b_count(cnt_b), .timer_a_ovf(ovf));
  csf_pad_model u_pad (.ctl(ac), .loaded, .noise, .osc);
  // bus-less access tasks, inputs change at falling edges
  task automatic cyc(int n); repeat (n) @(negedge clock); endtask
  task automatic wr0(logic en, logic rm, logic [1:0] rg, logic ta);
    @(negedge clock); w0 = 1'b1; c0 = '{en, rm, rg, ta}; cyc(1); w0 = 1'b0; cyc(2);
  endtask
  task automatic wra(logic s); @(negedge clock); wa = 1'b1; ta_src = s; cyc(1); wa = 1'b0; cyc(2); endtask
  task automatic wrb(logic [1:0] s, logic on, logic ge);
    @(negedge clock); wb = 1'b1; cb = '{s, on, ge}; cyc(1); wb = 1'b0; cyc(2);
  endtask
  // window of one first-timer overflow, count on second timer
  task automatic meas(output logic [15:0] r);
    @(negedge clock); ta_clr = 1'b1; tb_clr = 1'b1; ovf_clr = 1'b1;
    cyc(1); ta_clr = 1'b0; tb_clr = 1'b0; ovf_clr = 1'b0;
    `CHK(ovf, 1'b0)
    for (int i = 0; i < 400 && ovf !== 1'b1; i++) cyc(1);
    `CHK(ovf, 1'b1)
    r = cnt_b;
  endtask
  task automatic done(string s); $display("test %s done", s); endtask
  task automatic give_verdict();
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // watchdog far beyond the expected run
  initial begin
    repeat (20000) @(posedge clock);
    n_fail++;
    give_verdict();
  end
  // main sequence
  initial begin
    cyc(5); rst_b = 1'b1; cyc(1);
    `CHK(ac, 7'h0)
    `CHK(on_b, 1'b0)
    for (int m = 0; m < 2; m++) for (int r = 0; r < 4; r++) begin
      wr0(1'b1, m[0], r[1:0], 1'b0);
      `CHK(ac.var_ref_sel, m[0])
      `CHK(ac.range, exp_rng[m*4+r])
      `CHK(ac.current_src_en, r != 0)
      `CHK(ac.osc_path_en, m != 0 || r != 0)
    end
    done("decode");
    wr0(1'b1, 1'b0, 2'h1, 1'b1); wra(1'b0);
    `CHK(on_a, 1'b1)
    wra(1'b1);
    `CHK(on_a, 1'b0)
    wra(1'b0); wr0(1'b1, 1'b0, 2'h1, 1'b0);
    `CHK(on_a, 1'b0)
    wra(1'b1);
    for (int s = 0; s < 4; s++) begin
      wrb(s[1:0], 1'b1, 1'b0);
      `CHK(on_b, s == 3)
    end
    done("routing");
    meas(nom);
    `CHK(nom >= 16'd24 && nom <= 16'd26, 1'b1)
    loaded = 1'b1; cyc(10); meas(ld);
    `CHK(ld >= 16'd17 && ld <= 16'd19 && ld < nom, 1'b1)
    thr = (nom + ld) / 16'd2;
    `CHK(thr > ld && thr < nom, 1'b1)
    done("measure");
    wrb(`CSF_TB_SRC_SENSE, 1'b1, 1'b1); cyc(8); v = cnt_b; cyc(40);
    `CHK(cnt_b, v)
    gate = 1'b1; cyc(40);
    `CHK(cnt_b > v, 1'b1)
    wrb(`CSF_TB_SRC_SENSE, 1'b0, 1'b0); cyc(8); v = cnt_b; cyc(40);
    `CHK(cnt_b, v)
    wrb(`CSF_TB_SRC_SENSE, 1'b0, 1'b1); cyc(8); v = cnt_b; cyc(40);
    `CHK(cnt_b, v)
    done("gate");
    wrb(`CSF_TB_SRC_SENSE, 1'b1, 1'b0); wr0(1'b1, 1'b1, 2'h0, 1'b0); cyc(8); v = cnt_b; cyc(40);
    `CHK(cnt_b, v)
    `CHK(dir, osc)
    noise = 1'b1; cyc(40);
    `CHK(cnt_b > v, 1'b1)
    wr0(1'b0, 1'b0, 2'h1, 1'b0); cyc(8);
    `CHK(dir, 1'b0)
    done("noise");
    slp = 1'b1; cyc(2); va = cnt_a; cyc(20);
    `CHK(cnt_a, va)
    slp = 1'b0; cyc(4);
    `CHK(cnt_a != va, 1'b1)
    // external pins clock the timers when the oscillator is not routed
    wra(1'b0); wrb(`CSF_TB_SRC_PIN, 1'b1, 1'b0); cyc(8); va = cnt_a; v = cnt_b;
    repeat (3) begin
      pin_a = 1'b1; pin_b = 1'b1; cyc(6); pin_a = 1'b0; pin_b = 1'b0; cyc(6);
    end
    cyc(8);
    `CHK(cnt_a, va + 8'd3)
    `CHK(cnt_b, v + 16'd3)
    done("pins");
    // reset from a busy setting must bring the oscillator controls and second-timer routing back to idle
    wr0(1'b1, 1'b1, 2'h3, 1'b1); wrb(`CSF_TB_SRC_SENSE, 1'b1, 1'b0);
    rst_b = 1'b0; cyc(2); rst_b = 1'b1; cyc(1);
    `CHK(ac.range, CSF_RNG_OFF)
    `CHK(ac, 7'h0)
    `CHK(on_b, 1'b0)
    done("sleep and reset");
    give_verdict();
  end
endmodule
`default_nettype wire
